// ===== core/ulc_pkg.sv
package ulc_pkg;

   // ==========================================================
   // Register map
   localparam logic [31:0] STATUS_OFS = 32'h0000_001c;
   localparam logic [31:0] CONFIG_OFS = 32'h0000_0020;

   // ==========================================================
   // Status word fields
   localparam int ST_TXD = 31;
   localparam int ST_RTS = 30;
   localparam int ST_DTR = 29;
   localparam int ST_TXCNT_LO = 16;
   localparam int ST_RXD = 15;
   localparam int ST_CTS = 14;
   localparam int ST_DSR = 13;
   localparam int ST_RXCNT_LO = 0;

   // ==========================================================
   // Configuration word fields
   localparam int CF_DTR_INV = 24;
   localparam int CF_RTS_INV = 23;
   localparam int CF_TXD_INV = 22;
   localparam int CF_DSR_INV = 21;
   localparam int CF_CTS_INV = 20;
   localparam int CF_RXD_INV = 19;
   localparam int CF_TXF_RST = 18;
   localparam int CF_RXF_RST = 17;
   localparam int CF_FLOW_EN = 15;
   localparam int CF_LOOP = 14;
   localparam int CF_BRK = 8;
   localparam int CF_SOFT_DTR = 7;
   localparam int CF_SOFT_RTS = 6;
   localparam int CF_STOP_LO = 4;
   localparam int CF_LEN_LO = 2;
   localparam int CF_PAR_EN = 1;
   localparam int CF_PAR_ODD = 0;
   localparam logic [31:0] CONFIG_WMASK = 32'h01fe_c1ff;
   localparam logic [31:0] CONFIG_RST = 32'h0000_001c;

   // ==========================================================
   // Serial timing, in half-bit ticks, and the minimum data bit count
   localparam logic [2:0] HALVES_BIT = 3'h2;
   localparam logic [2:0] HALVES_STOP1 = 3'h2;
   localparam logic [2:0] HALVES_STOP15 = 3'h3;
   localparam logic [2:0] HALVES_STOP2 = 3'h4;
   localparam logic [3:0] MIN_BITS = 4'h5;

   // ==========================================================
   // Frame state machine, shared by transmitter and receiver
   typedef enum logic [4:0] {
      ULC_IDLE = 5'b00001,
      ULC_START = 5'b00010,
      ULC_DATA = 5'b00100,
      ULC_PAR = 5'b01000,
      ULC_STOP = 5'b10000
   } ulc_state_t;

endpackage

// ===== core/ulc_top.sv
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
// Contract
// - Status bit 30 shows the live request-to-send output level.
// - Status bit 29 shows the live data-terminal-ready output level.
// - Status bits 23:16 show the transmit FIFO entry count.
// - Status bit 15 shows the present serial receive input level.
// - Status bit 14 shows the present clear-to-send input level.
// - Status bit 13 shows the present data-set-ready input level.
// - Status bits 7:0 show the receive FIFO entry count.
// - Data-terminal-ready inversion flips that output; resets to zero.
// - Request-to-send inversion flips that output.
// - Transmit-data inversion flips the serial output level.
// - Data-set-ready inversion flips how that input is read.
// - Clear-to-send inversion flips how that input is read.
// - Receive-data inversion flips the serial input before sampling.
// - Transmit FIFO reset empties it and clears its count.
// - Receive FIFO reset empties it and clears its count.
// - Flow control holds off transmission while clear-to-send says not ready.
// - Loopback routes the transmit stream into the own receiver.
// - Stop length codes 1, 2, 3 give one, one and half, two bits.
// - Character length codes 0 to 3 give five to eight data bits.
// - Parity enable generates and checks a parity bit per character.
// - Parity type zero is even, one is odd.

// ==========================================================
// Simple FIFO with occupancy count
module ulc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [7:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = !flush && (cnt_q != 8'(DEPTH));
   assign out_valid = !flush && (cnt_q != 8'h00);
   assign out_data = mem[rd_q];
   assign count = cnt_q;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= 8'h00;
      end else if (flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= 8'h00;
      end else begin
         wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
         rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
         cnt_q <= 8'(cnt_q + {7'h00, push} - {7'h00, pop});
      end
   end
endmodule

// ==========================================================
// Line status and configuration with serial engine
module ulc_top #(
   parameter int DEPTH = 128,
   parameter logic [15:0] HALF_BIT = 16'h0010
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic txd,
   input wire logic rxd,
   input wire logic cts_n,
   input wire logic dsr_n,
   output logic rts_n,
   output logic dtr_n,
   output logic dsr_active,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_parity_err,
   output logic rx_frame_err
);
   // ==========================================================
   // Bus slave
   logic [31:0] cfg_q;
   logic [31:0] cfg_d;
   logic [31:0] addr_q;
   logic wr_pend_q;
   logic [31:0] hrdata_q;
   logic [31:0] status_w;
   wire addr_phase = hsel && hready && htrans[1];
   wire cfg_write = wr_pend_q && (addr_q == ulc_pkg::CONFIG_OFS);
   wire rd_status = addr_phase && !hwrite && (haddr == ulc_pkg::STATUS_OFS);
   wire rd_config = addr_phase && !hwrite && (haddr == ulc_pkg::CONFIG_OFS);
   wire [31:0] rd_word = rd_status ? status_w : (rd_config ? cfg_d : 32'h0000_0000);

   assign cfg_d = cfg_write ? (hwdata & ulc_pkg::CONFIG_WMASK) : cfg_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 32'h0000_0000;
         wr_pend_q <= 1'b0;
         hrdata_q <= 32'h0000_0000;
         cfg_q <= ulc_pkg::CONFIG_RST;
      end else begin
         wr_pend_q <= addr_phase && hwrite;
         addr_q <= addr_phase ? haddr : addr_q;
         hrdata_q <= addr_phase ? rd_word : hrdata_q;
         cfg_q <= cfg_d;
      end
   end

   // ==========================================================
   // Configuration decode
   wire dtr_inv = cfg_q[ulc_pkg::CF_DTR_INV];
   wire rts_inv = cfg_q[ulc_pkg::CF_RTS_INV];
   wire txd_inv = cfg_q[ulc_pkg::CF_TXD_INV];
   wire dsr_inv = cfg_q[ulc_pkg::CF_DSR_INV];
   wire cts_inv = cfg_q[ulc_pkg::CF_CTS_INV];
   wire rxd_inv = cfg_q[ulc_pkg::CF_RXD_INV];
   wire txf_rst = cfg_q[ulc_pkg::CF_TXF_RST];
   wire rxf_rst = cfg_q[ulc_pkg::CF_RXF_RST];
   wire flow_en = cfg_q[ulc_pkg::CF_FLOW_EN];
   wire loop_en = cfg_q[ulc_pkg::CF_LOOP];
   wire soft_terminal_ready = cfg_q[ulc_pkg::CF_SOFT_DTR];
   wire soft_request_send = cfg_q[ulc_pkg::CF_SOFT_RTS];
   wire [1:0] stop_code = cfg_q[ulc_pkg::CF_STOP_LO +: 2];
   wire [1:0] len_code = cfg_q[ulc_pkg::CF_LEN_LO +: 2];
   wire par_en = cfg_q[ulc_pkg::CF_PAR_EN];
   wire par_odd = cfg_q[ulc_pkg::CF_PAR_ODD];
   wire [3:0] nbits = ulc_pkg::MIN_BITS + {2'b00, len_code};
   wire [2:0] stop_halves = (stop_code == 2'h3) ? ulc_pkg::HALVES_STOP2 :
                            (stop_code == 2'h2) ? ulc_pkg::HALVES_STOP15 :
                            ulc_pkg::HALVES_STOP1;
   wire [7:0] len_mask = 8'hff >> (4'h8 - nbits);
   wire cts_n_eff = cts_n ^ cts_inv;
   wire tx_hold = flow_en && cts_n_eff;

   // ==========================================================
   // Modem control outputs
   logic rts_n_q;
   logic dtr_n_q;
   logic dsr_act_q;
   assign rts_n = rts_n_q;
   assign dtr_n = dtr_n_q;
   assign dsr_active = dsr_act_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rts_n_q <= 1'b1;
         dtr_n_q <= 1'b1;
         dsr_act_q <= 1'b0;
      end else begin
         rts_n_q <= !soft_request_send ^ rts_inv;
         dtr_n_q <= !soft_terminal_ready ^ dtr_inv;
         dsr_act_q <= !(dsr_n ^ dsr_inv);
      end
   end

   // ==========================================================
   // FIFOs
   logic [7:0] txf_data;
   logic txf_valid;
   logic txf_pop;
   logic [7:0] tx_cnt;
   logic [7:0] rx_cnt;
   logic [7:0] rx_word_q;
   logic rx_push_q;

   ulc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
      .clk(hclk),
      .rst_n(hresetn),
      .flush(txf_rst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(txf_data),
      .out_valid(txf_valid),
      .out_ready(txf_pop),
      .count(tx_cnt)
   );

   ulc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxf (
      .clk(hclk),
      .rst_n(hresetn),
      .flush(rxf_rst),
      .in_data(rx_word_q),
      .in_valid(rx_push_q),
      .in_ready(),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .count(rx_cnt)
   );

   // ==========================================================
   // Transmitter
   ulc_pkg::ulc_state_t tx_st_q;
   logic [15:0] tx_hcnt_q;
   logic [2:0] tx_half_q;
   logic [2:0] tx_bit_q;
   logic [7:0] tx_sh_q;
   logic tx_par_q;
   logic tx_serial;
   logic txd_q;
   wire tx_tick = (tx_hcnt_q == 16'h0000);
   wire [2:0] tx_need = (tx_st_q == ulc_pkg::ULC_STOP) ? stop_halves : ulc_pkg::HALVES_BIT;
   wire tx_bit_done = tx_tick && (tx_half_q == 3'(tx_need - 3'h1));
   wire tx_last = ({1'b0, tx_bit_q} == 4'(nbits - 4'h1));
   wire [7:0] tx_load = txf_data & len_mask;

   assign txf_pop = (tx_st_q == ulc_pkg::ULC_IDLE) && txf_valid && !tx_hold;
   assign tx_serial = (tx_st_q == ulc_pkg::ULC_START) ? 1'b0 :
                      (tx_st_q == ulc_pkg::ULC_DATA) ? tx_sh_q[0] :
                      (tx_st_q == ulc_pkg::ULC_PAR) ? tx_par_q : 1'b1;
   assign txd = txd_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st_q <= ulc_pkg::ULC_IDLE;
         tx_hcnt_q <= 16'h0000;
         tx_half_q <= 3'h0;
         tx_bit_q <= 3'h0;
         tx_sh_q <= 8'h00;
         tx_par_q <= 1'b0;
         txd_q <= 1'b1;
      end else begin
         txd_q <= (loop_en ? 1'b1 : tx_serial) ^ txd_inv;
         tx_hcnt_q <= (tx_tick || tx_st_q == ulc_pkg::ULC_IDLE) ?
                      16'(HALF_BIT - 16'h0001) : 16'(tx_hcnt_q - 16'h0001);
         if (tx_st_q == ulc_pkg::ULC_IDLE || tx_bit_done) begin
            tx_half_q <= 3'h0;
         end else if (tx_tick) begin
            tx_half_q <= 3'(tx_half_q + 3'h1);
         end
         case (tx_st_q)
            ulc_pkg::ULC_IDLE: begin
               if (txf_pop) begin
                  tx_sh_q <= tx_load;
                  tx_par_q <= ^tx_load ^ par_odd;
                  tx_st_q <= ulc_pkg::ULC_START;
               end
            end
            ulc_pkg::ULC_START: begin
               if (tx_bit_done) begin
                  tx_bit_q <= 3'h0;
                  tx_st_q <= ulc_pkg::ULC_DATA;
               end
            end
            ulc_pkg::ULC_DATA: begin
               if (tx_bit_done) begin
                  tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                  tx_bit_q <= 3'(tx_bit_q + 3'h1);
                  if (tx_last) begin
                     tx_st_q <= par_en ? ulc_pkg::ULC_PAR : ulc_pkg::ULC_STOP;
                  end
               end
            end
            ulc_pkg::ULC_PAR: begin
               if (tx_bit_done) begin
                  tx_st_q <= ulc_pkg::ULC_STOP;
               end
            end
            ulc_pkg::ULC_STOP: begin
               if (tx_bit_done) begin
                  tx_st_q <= ulc_pkg::ULC_IDLE;
               end
            end
            default: begin
               tx_st_q <= ulc_pkg::ULC_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Receiver, sampling at mid-bit
   ulc_pkg::ulc_state_t rx_st_q;
   logic [15:0] rx_hcnt_q;
   logic rx_half_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_sh_q;
   logic rx_line_q;
   logic rx_perr_q;
   logic rx_ferr_q;
   wire rx_tick = (rx_hcnt_q == 16'h0000);
   wire rx_sample = rx_tick && rx_half_q;
   wire rx_last = ({1'b0, rx_bit_q} == 4'(nbits - 4'h1));
   wire rx_par_bad = (^rx_sh_q ^ par_odd) != rx_line_q;

   assign rx_parity_err = rx_perr_q;
   assign rx_frame_err = rx_ferr_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_st_q <= ulc_pkg::ULC_IDLE;
         rx_hcnt_q <= 16'h0000;
         rx_half_q <= 1'b0;
         rx_bit_q <= 3'h0;
         rx_sh_q <= 8'h00;
         rx_line_q <= 1'b1;
         rx_perr_q <= 1'b0;
         rx_ferr_q <= 1'b0;
         rx_word_q <= 8'h00;
         rx_push_q <= 1'b0;
      end else begin
         rx_line_q <= loop_en ? tx_serial : (rxd ^ rxd_inv);
         rx_push_q <= 1'b0;
         rx_perr_q <= 1'b0;
         rx_ferr_q <= 1'b0;
         rx_hcnt_q <= (rx_tick || rx_st_q == ulc_pkg::ULC_IDLE) ?
                      16'(HALF_BIT - 16'h0001) : 16'(rx_hcnt_q - 16'h0001);
         if (rx_st_q == ulc_pkg::ULC_IDLE || rx_st_q == ulc_pkg::ULC_START) begin
            rx_half_q <= 1'b0;
         end else if (rx_tick) begin
            rx_half_q <= !rx_half_q;
         end
         case (rx_st_q)
            ulc_pkg::ULC_IDLE: begin
               if (!rx_line_q) begin
                  rx_st_q <= ulc_pkg::ULC_START;
               end
            end
            ulc_pkg::ULC_START: begin
               if (rx_tick) begin
                  rx_bit_q <= 3'h0;
                  rx_sh_q <= 8'h00;
                  rx_st_q <= rx_line_q ? ulc_pkg::ULC_IDLE : ulc_pkg::ULC_DATA;
               end
            end
            ulc_pkg::ULC_DATA: begin
               if (rx_sample) begin
                  rx_sh_q[rx_bit_q] <= rx_line_q;
                  rx_bit_q <= 3'(rx_bit_q + 3'h1);
                  if (rx_last) begin
                     rx_st_q <= par_en ? ulc_pkg::ULC_PAR : ulc_pkg::ULC_STOP;
                  end
               end
            end
            ulc_pkg::ULC_PAR: begin
               if (rx_sample) begin
                  rx_perr_q <= rx_par_bad;
                  rx_st_q <= ulc_pkg::ULC_STOP;
               end
            end
            ulc_pkg::ULC_STOP: begin
               if (rx_sample) begin
                  rx_ferr_q <= !rx_line_q;
                  rx_push_q <= rx_line_q && !rxf_rst;
                  rx_word_q <= rx_sh_q;
                  rx_st_q <= ulc_pkg::ULC_IDLE;
               end
            end
            default: begin
               rx_st_q <= ulc_pkg::ULC_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Status word
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[ulc_pkg::ST_TXD] = txd_q;
      status_w[ulc_pkg::ST_RTS] = rts_n_q;
      status_w[ulc_pkg::ST_DTR] = dtr_n_q;
      status_w[ulc_pkg::ST_TXCNT_LO +: 8] = tx_cnt;
      status_w[ulc_pkg::ST_RXD] = rxd;
      status_w[ulc_pkg::ST_CTS] = cts_n;
      status_w[ulc_pkg::ST_DSR] = dsr_n;
      status_w[ulc_pkg::ST_RXCNT_LO +: 8] = rx_cnt;
   end
endmodule

// ===== test/ulc_top_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the status word and modem outputs
module ulc_top_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic rxd,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic rts_n,
   input wire logic dtr_n,
   input wire logic dsr_active,
   input wire logic rx_valid
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wr_pend_q;
   logic [31:0] sh_q;
   wire take = hsel & hready & htrans[1];
   wire rd_st = take & !hwrite & (haddr == ulc_pkg::STATUS_OFS);
   wire wr_cf = take & hwrite & (haddr == ulc_pkg::CONFIG_OFS);
   // Shadow of the configuration word as software wrote it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         sh_q <= ulc_pkg::CONFIG_RST;
      end else begin
         wr_pend_q <= wr_cf;
         if (wr_pend_q)
            sh_q <= hwdata & ulc_pkg::CONFIG_WMASK;
      end
   end
   // ==========================================================
   // Assertions
   property p_st_rts;
      rd_st |=> hrdata[30] == $past(rts_n);
   endproperty
   a_st_rts: assert property (p_st_rts) else $error("status rts bit wrong");
   property p_st_dtr;
      rd_st |=> hrdata[29] == $past(dtr_n);
   endproperty
   a_st_dtr: assert property (p_st_dtr) else $error("status dtr bit wrong");
   property p_st_rxd;
      rd_st ##1 1'b1 |-> hrdata[15] == $past(rxd);
   endproperty
   a_st_rxd: assert property (p_st_rxd) else $error("status rxd bit wrong");
   property p_st_cts;
      rd_st |=> hrdata[14] == $past(cts_n);
   endproperty
   a_st_cts: assert property (p_st_cts) else $error("status cts bit wrong");
   property p_st_dsr;
      rd_st |=> hrdata[13] == $past(dsr_n);
   endproperty
   a_st_dsr: assert property (p_st_dsr) else $error("status dsr bit wrong");
   property p_dtr;
      $past(hresetn) |-> dtr_n == (!$past(sh_q[7]) ^ $past(sh_q[24]));
   endproperty
   a_dtr: assert property (p_dtr) else $error("dtr output level wrong");
   property p_rts;
      $past(hresetn) |-> rts_n == (!$past(sh_q[6]) ^ $past(sh_q[23]));
   endproperty
   a_rts: assert property (p_rts) else $error("rts output level wrong");
   property p_dsr;
      $past(hresetn) |-> dsr_active == !($past(dsr_n) ^ $past(sh_q[21]));
   endproperty
   a_dsr: assert property (p_dsr) else $error("dsr active level wrong");
   c_st: cover property (rd_st);
   c_wr: cover property (wr_cf ##2 $changed(dtr_n));
   c_rx: cover property ($rose(rx_valid));
endmodule

bind ulc_top ulc_top_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .rxd, .cts_n, .dsr_n, .rts_n, .dtr_n, .dsr_active, .rx_valid);

// ===== test/ulc_peer.sv
`timescale 1ns/1ps
// ==========================================================
// Remote serial peer on the line side
module ulc_peer #(
   parameter int BIT = 8
) (
   input wire logic hclk,
   input wire logic txd,
   output logic rxd = 1'b1,
   output logic cts_n = 1'b1,
   output logic dsr_n = 1'b1
);
   // One frame LSB first, two stop bits; inv drives the line inverted
   task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pv,
         input logic inv);
      rxd <= inv;
      repeat (BIT) @(posedge hclk);
      for (int i = 0; i < nb; i++) begin
         rxd <= d[i] ^ inv;
         repeat (BIT) @(posedge hclk);
      end
      if (pe) begin
         rxd <= pv ^ inv;
         repeat (BIT) @(posedge hclk);
      end
      rxd <= ~inv;
      repeat (2 * BIT) @(posedge hclk);
   endtask
   // Clocks of the first low stretch on txd and of the high stretch after it
   task automatic measure(output int lo, output int hi);
      lo = 0;
      hi = 0;
      @(negedge txd);
      @(negedge hclk);
      while (txd === 1'b0 && lo < 400) begin
         lo++;
         @(negedge hclk);
      end
      while (txd === 1'b1 && hi < 400) begin
         hi++;
         @(negedge hclk);
      end
   endtask
endmodule

// ===== test/test_ulc_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench: register bus, modem lines and serial streams
module test_ulc_top;
   localparam logic [15:0] HB = 16'h0004;
   localparam logic [31:0] B = 32'h0000_001c;
   localparam logic [31:0] ST = ulc_pkg::STATUS_OFS;
   localparam logic [31:0] CF = ulc_pkg::CONFIG_OFS;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] tx_data = 8'h0;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   wire hready, hresp, txd, rxd, cts_n, dsr_n, rts_n, dtr_n, dsr_active;
   wire tx_ready, rx_valid, perr, ferr;
   wire [31:0] hrdata;
   wire [7:0] rx_data;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   int perr_cnt = 0;
   int ferr_cnt = 0;
   int lo, hi, e, hx;
   logic [31:0] r, d;
   ulc_top #(.DEPTH(128), .HALF_BIT(HB)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp, .txd, .rxd, .cts_n, .dsr_n,
      .rts_n, .dtr_n, .dsr_active, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
      .rx_ready, .rx_parity_err(perr), .rx_frame_err(ferr));
   ulc_peer #(.BIT(2 * int'(HB))) PEER (.hclk, .txd, .rxd, .cts_n, .dsr_n);
   always #5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc++;
      if (perr === 1'b1)
         perr_cnt++;
      if (ferr === 1'b1)
         ferr_cnt++;
      if (cyc == 60000) begin
         error_cnt++;
         $display("unexpected at %0t: run too long", $time);
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Single AHB-Lite word transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         @(posedge hclk);
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         @(posedge hclk);
      end
      r = hrdata;
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m,
         input string s);
      ahb(1'b0, a, 32'h0);
      chk(r & m, x, s);
      chk(hresp, 0, "okay response");
   endtask
   task automatic cfg(input logic [31:0] v);
      ahb(1'b1, CF, v);
      tick(3);
   endtask
   task automatic push(input logic [7:0] v);
      tx_data <= v;
      tx_valid <= 1'b1;
      @(posedge hclk);
      while (tx_ready !== 1'b1) begin
         @(posedge hclk);
      end
      tx_valid <= 1'b0;
      @(posedge hclk);
   endtask
   initial begin
      tick(6);
      hresetn <= 1'b1;
      tick(1);
      rdc(CF, B, '1, "config reset");
      rdc(ST, 32'he000_e000, '1, "status reset");
      rdc(32'h40, 32'h0, '1, "unmapped read");
      ahb(1'b1, ST, 32'hffff_ffff);
      rdc(ST, 32'he000_e000, '1, "status write ignored");
      for (int k = 0; k < 16; k++) begin
         d = B | {7'h0, k[3], k[2], 15'h0, k[1], k[0], 6'h0};
         cfg(d);
         chk(dtr_n, !k[1] ^ k[3], "dtr level");
         chk(rts_n, !k[0] ^ k[2], "rts level");
         rdc(ST, {1'b1, !k[0] ^ k[2], !k[1] ^ k[3], 29'h0}, 32'he000_0000, "modem bits");
         rdc(CF, d, '1, "config readback");
      end
      for (int j = 0; j < 4; j++) begin
         PEER.dsr_n <= j[0];
         PEER.cts_n <= j[1];
         cfg(B | {10'h0, j[1], 21'h0});
         chk(dsr_active, !(j[0] ^ j[1]), "dsr active");
         rdc(ST, {j[1], j[0], 13'h0}, 32'h0000_6000, "cts dsr bits");
      end
      PEER.rxd <= 1'b0;
      tick(4);
      rdc(ST, 32'h0, 32'h0000_8000, "rxd bit");
      tick(80);
      PEER.rxd <= 1'b1;
      tick(200);
      chk(ferr_cnt, 1, "low stop bit");
      cfg(B | 32'h0000_8000);
      for (int i = 0; i < 3; i++)
         push(8'h00);
      tick(60);
      rdc(ST, 32'h0003_0000, 32'h00ff_0000, "held tx count");
      fork
         PEER.measure(lo, hi);
         PEER.cts_n <= 1'b0;
      join
      chk(lo, 9 * 2 * HB, "8 bit low time");
      tick(300);
      rdc(ST, 32'h0, 32'h00ff_0000, "tx drained");
      for (int s = 0; s < 4; s++) begin
         cfg({26'h0, s[1:0], s[1:0], 2'h0});
         fork
            PEER.measure(lo, hi);
            begin
               push(8'h00);
               push(8'h00);
            end
         join
         chk(lo, (6 + s) * 2 * HB, "char low time");
         hx = (s == 0 ? 2 : s + 1) * HB;
         chk(hi >= hx && hi <= hx + 3, 1, "stop length");
         tick(300);
      end
      cfg(B | 32'h0040_0000);
      chk(txd, 0, "inverted idle");
      rdc(ST, 32'h0, 32'h8000_0000, "txd bit");
      PEER.cts_n <= 1'b1;
      cfg(B | 32'h0000_8000);
      push(8'h11);
      push(8'h22);
      cfg(B | 32'h0004_8000);
      rdc(ST, 32'h0, 32'h00ff_0000, "tx reset count");
      chk(tx_ready, 0, "tx refused in reset");
      cfg(B | 32'h0000_8000);
      rdc(ST, 32'h0, 32'h00ff_0000, "tx stays empty");
      cfg(B | 32'h0002_0000);
      cfg(B);
      PEER.send(8'ha5, 8, 1'b0, 1'b0, 1'b0);
      tick(20);
      rdc(ST, 32'h1, 32'hff, "rx count");
      chk(rx_data, 8'ha5, "rx byte");
      for (int k = 0; k < 4; k++) begin
         cfg(B | {30'h0, 1'b1, k[1]});
         e = perr_cnt;
         PEER.send(8'h03, 8, 1'b1, k[0], 1'b0);
         tick(20);
         chk(perr_cnt - e, k[0] ^ k[1], "parity flag");
      end
      rdc(ST, 32'h5, 32'hff, "parity frames kept");
      cfg(B | 32'h0002_0000);
      rdc(ST, 32'h0, 32'hff, "rx reset count");
      chk(rx_valid, 0, "rx empty");
      PEER.rxd <= 1'b0;
      cfg(B | 32'h000a_0000);
      tick(200);
      cfg(B | 32'h0008_0000);
      PEER.send(8'h3c, 8, 1'b0, 1'b0, 1'b1);
      tick(20);
      rdc(ST, 32'h1, 32'hff, "inverted rx count");
      chk(rx_data, 8'h3c, "inverted rx byte");
      rx_ready <= 1'b1;
      tick(1);
      rx_ready <= 1'b0;
      tick(1);
      chk(rx_valid, 0, "popped");
      for (int s = 0; s < 4; s++) begin
         d = 32'h0000_4010 | (s << 2);
         cfg(d | 32'h0002_0000);
         cfg(d);
         PEER.rxd <= 1'b1;
         push(8'hff);
         tick(3);
         chk(txd, 1, "loopback holds txd");
         tick(147);
         chk(rx_data, 8'hff >> (3 - s), "loopback byte");
      end
      tally_and_finish();
   end
endmodule
